// >>> cfg_fwd_defs.svh
/*
 * Constants for the configuration forwarding decoder: bus commands,
 * address field positions and special-cycle keys.
 * Assumes inclusion by bare name from every design file that needs them.
 */
`ifndef CFG_FWD_DEFS_SVH
`define CFG_FWD_DEFS_SVH

// ============================================================
// bus commands on the command/byte-enable lines
`define CMD_CFG_RD 4'hA
`define CMD_CFG_WR 4'hB
`define CMD_SPECIAL 4'h1

// ============================================================
// address field positions and encodings
`define ADDR_TYPE0 2'h0
`define ADDR_TYPE1 2'h1
`define BUS_MSB 23
`define BUS_LSB 16
`define DEV_MSB 15
`define DEV_LSB 11
`define FUNC_MSB 10
`define FUNC_LSB 8
`define REG_MSB 7
`define REG_LSB 2
`define DEV_ALL_ONES 5'h1F
`define FUNC_ALL_ONES 3'h7
`define REG_SPECIAL 6'h00
`define IDSEL_LSB 16
`define IDSEL_DEV_LIMIT 5'h10

`endif

// >>> cfg_fwd_pkg.sv
/*
 * Types shared by the configuration forwarding decoder files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cfg_fwd_pkg;

    // ============================================================
    // how a configuration request is forwarded
    typedef enum logic [2:0] {
        FWD_NONE,
        FWD_TYPE0,
        FWD_T1_DOWN,
        FWD_T1_UP,
        FWD_SPECIAL
    } fwd_kind_t;

    // ============================================================
    // delayed transaction progress
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_DONE
    } dt_state_t;

endpackage

// >>> cfg_fwd_decode.sv
/*
 * Address-phase decoder: classifies a configuration request and builds
 * the address and command to be driven on the target bus.
 * Assumes inputs are stable during the address phase, on the bus clock.
 */
`include "cfg_fwd_defs.svh"

module cfg_fwd_decode
(
    // request seen in the address phase
    input wire logic req_primary,
    input wire logic [31:0] req_addr,
    input wire logic [3:0] req_cmd,
    // bus number registers
    input wire logic [7:0] primary_bus,
    input wire logic [7:0] secondary_bus,
    input wire logic [7:0] subordinate_bus,
    // decode result
    output cfg_fwd_pkg::fwd_kind_t kind,
    output logic [31:0] out_addr,
    output logic [3:0] out_cmd
);

    // ============================================================
    // one-hot select line for devices below the limit, else nothing
    function automatic logic [15:0] idsel_pattern(input logic [4:0] dev);
        idsel_pattern = (dev < `IDSEL_DEV_LIMIT) ? (16'h0001 << dev[3:0]) : 16'h0000;
    endfunction

    // ============================================================
    // field extraction
    wire logic [7:0] bus_num = req_addr[`BUS_MSB:`BUS_LSB];
    wire logic [4:0] dev_num = req_addr[`DEV_MSB:`DEV_LSB];
    wire logic [2:0] func_num = req_addr[`FUNC_MSB:`FUNC_LSB];
    wire logic [5:0] reg_num = req_addr[`REG_MSB:`REG_LSB];
    wire logic is_type1 = req_addr[1:0] == `ADDR_TYPE1;
    wire logic is_wr = req_cmd == `CMD_CFG_WR;
    wire logic is_cfg = is_wr || (req_cmd == `CMD_CFG_RD);
    wire logic bcast = (dev_num == `DEV_ALL_ONES) && (func_num == `FUNC_ALL_ONES);
    wire logic spec_key = is_type1 && is_wr && bcast && (reg_num == `REG_SPECIAL);
    wire logic in_range = (bus_num >= secondary_bus) && (bus_num <= subordinate_bus);

    // ============================================================
    // classification; special-cycle commands on either bus fall to none
    wire logic hit_spec_dn = req_primary && spec_key && (bus_num == secondary_bus);
    wire logic hit_spec_up = !req_primary && spec_key && (bus_num == primary_bus);
    wire logic hit_t0 = req_primary && is_type1 && is_cfg && (bus_num == secondary_bus);
    wire logic hit_dn = req_primary && is_type1 && is_cfg && (bus_num > secondary_bus)
        && (bus_num <= subordinate_bus);
    wire logic hit_up = !req_primary && is_type1 && is_wr && bcast && !in_range;

    assign kind = (hit_spec_dn || hit_spec_up) ? cfg_fwd_pkg::FWD_SPECIAL :
                  hit_t0 ? cfg_fwd_pkg::FWD_TYPE0 :
                  hit_dn ? cfg_fwd_pkg::FWD_T1_DOWN :
                  hit_up ? cfg_fwd_pkg::FWD_T1_UP : cfg_fwd_pkg::FWD_NONE;

    // ============================================================
    // target-bus address and command
    wire logic [31:0] type0_addr = {idsel_pattern(dev_num), 5'h00, func_num, reg_num,
        `ADDR_TYPE0};
    assign out_addr = (kind == cfg_fwd_pkg::FWD_TYPE0) ? type0_addr : req_addr;
    assign out_cmd = (kind == cfg_fwd_pkg::FWD_SPECIAL) ? `CMD_SPECIAL : req_cmd;

endmodule

// >>> cfg_fwd_core.sv
/*
 * Configuration forwarding core: claims configuration requests, queues
 * them as delayed transactions and answers the repeats.
 * Assumes the bus engines and the transaction queue run on clk, present
 * one-cycle request and completion pulses, and execute one data phase.
 */
// Contract
// - device 0-15 drives one-hot bit 16+dev on secondary upper address.
// - device 16-31 drives upper address zero but still forwards.
// - unselected secondary target ends in master abort, reflected to initiator.
// - type 0 translated accesses run as delayed transactions.
// - translated accesses move exactly one doubleword.
// - claim downstream type 1 when secondary < bus <= subordinate.
// - downstream type 1 forwarding keeps address, command, data unchanged.
// - upstream type 1 write only for out-of-range bus, broadcast device/function.
// - type 1 forwarded writes are delayed, single data phase.
// - special-cycle commands on either bus are never claimed.
// - matching type 1 write with register zero becomes special cycle.
// - special cycle swaps command only, address and data pass through.
// - special-cycle master abort is not reported; repeat completes with data ready.
// - multi-phase request on special conversion gets disconnect in first phase.
// - type 0 translation only downstream on secondary bus number match.
// - type 0 address forces bits 1:0 and 15:11 to zero.
`include "cfg_fwd_defs.svh"

module cfg_fwd_core
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // bus number registers
    input wire logic [7:0] primary_bus,
    input wire logic [7:0] secondary_bus,
    input wire logic [7:0] subordinate_bus,
    // initiator request, address phase pulse
    input wire logic req_valid,
    input wire logic req_primary,
    input wire logic [31:0] req_addr,
    input wire logic [3:0] req_cmd,
    input wire logic [31:0] req_data,
    input wire logic req_multi,
    // answer to the initiator, one-cycle pulse
    output logic resp_valid_q,
    output logic resp_devsel_q,
    output logic resp_trdy_q,
    output logic resp_stop_q,
    output logic [31:0] resp_data_q,
    // request towards the delayed transaction queue
    input wire logic fwd_ready,
    output logic fwd_push_q,
    output logic fwd_to_secondary_q,
    output logic [31:0] fwd_addr_q,
    output logic [3:0] fwd_cmd_q,
    output logic [31:0] fwd_data_q,
    output logic fwd_single_q,
    // completion from the target bus
    input wire logic cpl_valid,
    input wire logic cpl_master_abort,
    input wire logic cpl_target_abort,
    input wire logic [31:0] cpl_data,
    // status event towards the status registers
    output logic ma_report_q
);

    // ============================================================
    // decode of the current request
    cfg_fwd_pkg::fwd_kind_t kind;
    logic [31:0] dec_addr;
    logic [3:0] dec_cmd;

    cfg_fwd_decode u_decode
    (
        .req_primary(req_primary),
        .req_addr(req_addr),
        .req_cmd(req_cmd),
        .primary_bus(primary_bus),
        .secondary_bus(secondary_bus),
        .subordinate_bus(subordinate_bus),
        .kind(kind),
        .out_addr(dec_addr),
        .out_cmd(dec_cmd)
    );

    // ============================================================
    // held state of the one outstanding delayed transaction
    cfg_fwd_pkg::dt_state_t state_q, state_d;
    cfg_fwd_pkg::fwd_kind_t kind_q;
    logic [31:0] addr_q;
    logic [3:0] cmd_q;
    logic side_q;
    logic ma_q;
    logic ta_q;
    logic [31:0] rdata_q;

    // ============================================================
    // request classification against the held transaction
    wire logic claim = req_valid && (kind != cfg_fwd_pkg::FWD_NONE);
    wire logic same = (req_addr == addr_q) && (req_cmd == cmd_q) && (req_primary == side_q);
    wire logic start = claim && (state_q == cfg_fwd_pkg::ST_IDLE) && fwd_ready;
    wire logic finish = claim && same && (state_q == cfg_fwd_pkg::ST_DONE);
    wire logic got_cpl = cpl_valid && (state_q == cfg_fwd_pkg::ST_WAIT);
    wire logic is_spec_q = kind_q == cfg_fwd_pkg::FWD_SPECIAL;
    // special cycles always end in master abort; that is success here
    wire logic reflect_ma = ma_q && !is_spec_q;
    // every claimed request that does not finish is retried; one entry only
    wire logic retry = claim && !finish;

    // next state
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            cfg_fwd_pkg::ST_IDLE:
                if (start)
                    state_d = cfg_fwd_pkg::ST_WAIT;
            cfg_fwd_pkg::ST_WAIT:
                if (cpl_valid)
                    state_d = cfg_fwd_pkg::ST_DONE;
            cfg_fwd_pkg::ST_DONE:
                if (finish)
                    state_d = cfg_fwd_pkg::ST_IDLE;
            default:
                state_d = cfg_fwd_pkg::ST_IDLE;
        endcase
    end

    // ============================================================
    // answer codes: retry, completion, target abort, reflected abort
    wire logic ans_devsel = retry || (finish && !ma_q && !ta_q) || (finish && is_spec_q);
    wire logic ans_trdy = finish && !ta_q && !reflect_ma;
    // a repeat wanting more than one phase is cut after the first
    wire logic ans_stop = retry || (finish && ta_q) || (ans_trdy && req_multi);

    // transaction state registers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_q <= cfg_fwd_pkg::ST_IDLE;
            kind_q <= cfg_fwd_pkg::FWD_NONE;
            addr_q <= 32'h0000_0000;
            cmd_q <= 4'h0;
            side_q <= 1'b0;
            ma_q <= 1'b0;
            ta_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            state_q <= state_d;
            if (start)
            begin
                kind_q <= kind;
                addr_q <= req_addr;
                cmd_q <= req_cmd;
                side_q <= req_primary;
            end
            if (got_cpl)
            begin
                ma_q <= cpl_master_abort;
                ta_q <= cpl_target_abort;
                rdata_q <= cpl_data;
            end
        end
    end

    // answer to the initiator
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            resp_valid_q <= 1'b0;
            resp_devsel_q <= 1'b0;
            resp_trdy_q <= 1'b0;
            resp_stop_q <= 1'b0;
            resp_data_q <= 32'h0000_0000;
        end
        else
        begin
            resp_valid_q <= claim;
            resp_devsel_q <= ans_devsel;
            resp_trdy_q <= ans_trdy;
            resp_stop_q <= ans_stop;
            resp_data_q <= rdata_q;
        end
    end

    // forwarded request and status event
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            fwd_push_q <= 1'b0;
            fwd_to_secondary_q <= 1'b0;
            fwd_addr_q <= 32'h0000_0000;
            fwd_cmd_q <= 4'h0;
            fwd_data_q <= 32'h0000_0000;
            fwd_single_q <= 1'b0;
            ma_report_q <= 1'b0;
        end
        else
        begin
            fwd_push_q <= start;
            if (start)
            begin
                fwd_to_secondary_q <= req_primary;
                fwd_addr_q <= dec_addr;
                fwd_cmd_q <= dec_cmd;
                fwd_data_q <= req_data;
                fwd_single_q <= 1'b1;
            end
            ma_report_q <= got_cpl && cpl_master_abort && !is_spec_q;
        end
    end

    // ============================================================
    // checks
    wire logic [4:0] held_dev = addr_q[`DEV_MSB:`DEV_LSB];
    wire logic push_t0 = fwd_push_q && (kind_q == cfg_fwd_pkg::FWD_TYPE0);

    a_idsel_one_hot: assert property (@(posedge clk) disable iff (reset)
        push_t0 && (held_dev < `IDSEL_DEV_LIMIT) |->
        fwd_addr_q[31:16] == (16'h0001 << held_dev[3:0]))
        else $error("select line pattern wrong for low device number");
    a_idsel_high_zero: assert property (@(posedge clk) disable iff (reset)
        push_t0 && (held_dev >= `IDSEL_DEV_LIMIT) |-> fwd_addr_q[31:16] == 16'h0000)
        else $error("upper address not zero for high device number");
    a_type0_fields: assert property (@(posedge clk) disable iff (reset)
        push_t0 |-> fwd_addr_q[1:0] == 2'h0 && fwd_addr_q[15:11] == 5'h00
        && fwd_addr_q[10:2] == addr_q[10:2])
        else $error("type 0 address fields wrong");
    a_start_retried: assert property (@(posedge clk) disable iff (reset)
        start |=> fwd_push_q && resp_devsel_q && resp_stop_q && !resp_trdy_q)
        else $error("new request not retried and queued");
    a_single_phase: assert property (@(posedge clk) disable iff (reset)
        fwd_push_q |-> fwd_single_q) else $error("forward not limited to one phase");
    a_down_intact: assert property (@(posedge clk) disable iff (reset)
        fwd_push_q && kind_q == cfg_fwd_pkg::FWD_T1_DOWN |->
        fwd_addr_q == addr_q && fwd_cmd_q == cmd_q)
        else $error("downstream type 1 altered");
    a_special_cmd: assert property (@(posedge clk) disable iff (reset)
        fwd_push_q && is_spec_q |-> fwd_cmd_q == `CMD_SPECIAL && fwd_addr_q == addr_q)
        else $error("special cycle command or address wrong");
    a_special_ignored: assert property (@(posedge clk) disable iff (reset)
        req_valid && req_cmd == `CMD_SPECIAL |=> !resp_valid_q && !fwd_push_q)
        else $error("special cycle command claimed");
    a_special_silent: assert property (@(posedge clk) disable iff (reset)
        finish && is_spec_q |=> resp_trdy_q && resp_devsel_q && !ma_report_q)
        else $error("special cycle repeat not completed quietly");
    a_multi_disconnect: assert property (@(posedge clk) disable iff (reset)
        finish && is_spec_q && req_multi |=> resp_stop_q && resp_trdy_q)
        else $error("no disconnect on multi-phase special write");
    a_abort_reflected: assert property (@(posedge clk) disable iff (reset)
        finish && ma_q && !is_spec_q |=> resp_valid_q && !resp_devsel_q && !resp_stop_q
        && !resp_trdy_q)
        else $error("master abort not reflected");

endmodule

// >>> cfg_fwd_far_model.sv
/*
 * Far-side model: stands in for the transaction queue and the target bus.
 * Assumes the core pushes one request at a time, all on clk.
 */
module cfg_fwd_far_model
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // forwarded request
    input wire logic fwd_push_q,
    input wire logic [31:0] fwd_addr_q,
    input wire logic [3:0] fwd_cmd_q,
    // scenario knobs
    input wire logic [7:0] cpl_delay,
    input wire logic force_ta,
    // completion
    output logic fwd_ready,
    output logic cpl_valid,
    output logic cpl_master_abort,
    output logic cpl_target_abort,
    output logic [31:0] cpl_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy_q;
    logic ma_q;
    logic [7:0] count_q;
    logic [31:0] addr_q;

    // ============================================================
    // target selection
    // nobody answers a special cycle or a type 0 access with no select line
    wire logic no_target = fwd_cmd_q == 4'h1 ||
        (fwd_addr_q[1:0] == 2'h0 && fwd_addr_q[31:16] == 16'h0);
    assign fwd_ready = !busy_q;

    // one transaction in flight; idle data toggles so stale values never match
    always_ff @(posedge clk)
    begin
        cpl_valid <= 1'b0;
        cpl_master_abort <= 1'b0;
        cpl_target_abort <= 1'b0;
        cpl_data <= ~cpl_data;
        if (reset)
        begin
            busy_q <= 1'b0;
            cpl_data <= 32'h5A5A_5A5A;
        end
        else if (!busy_q && fwd_push_q)
        begin
            busy_q <= 1'b1;
            count_q <= cpl_delay;
            addr_q <= fwd_addr_q;
            ma_q <= no_target;
        end
        else if (busy_q && count_q == 8'h00)
        begin
            busy_q <= 1'b0;
            cpl_valid <= 1'b1;
            cpl_master_abort <= ma_q;
            cpl_target_abort <= force_ta && !ma_q;
            cpl_data <= ~addr_q;
        end
        else if (busy_q)
        begin
            count_q <= count_q - 8'h01;
        end
    end
endmodule

// >>> config_cycle_forwarding_decoder_test.sv
/*
 * Self-checking bench for cfg_fwd_core with the far-side model.
 * Assumes a 20 MHz clock; inputs change on the falling edge.
 */
module config_cycle_forwarding_decoder_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic prim; logic [31:0] addr; logic [3:0] cmd; logic push;
        logic to_sec; logic [31:0] faddr; logic [3:0] fcmd;} case_t;
    logic clk, reset, req_valid, req_primary, req_multi, fwd_ready, force_ta;
    logic [31:0] req_addr, req_data, resp_data_q, fwd_addr_q, fwd_data_q, cpl_data;
    logic [3:0] req_cmd, fwd_cmd_q;
    logic [7:0] cpl_delay;
    logic resp_valid_q, resp_devsel_q, resp_trdy_q, resp_stop_q, fwd_push_q;
    logic fwd_to_secondary_q, fwd_single_q, cpl_valid, cpl_master_abort;
    logic cpl_target_abort, ma_report_q;
    // answer latched while it stands: {push, valid, devsel, trdy, stop}
    logic [31:0] seen_ans;
    int miscompares = 0;
    int check_count = 0;
    // ============================================================
    // case table: primary bus 1, secondary 2, subordinate 5
    case_t rows[16] = '{
        '{1'b1, 32'h0002_0215, 4'hA, 1'b1, 1'b1, 32'h0001_0214, 4'hA},
        '{1'b1, 32'h0002_7805, 4'hB, 1'b1, 1'b1, 32'h8000_0004, 4'hB},
        '{1'b1, 32'h0002_800D, 4'hA, 1'b1, 1'b1, 32'h0000_000C, 4'hA},
        '{1'b1, 32'h0002_3F01, 4'hA, 1'b1, 1'b1, 32'h0080_0700, 4'hA},
        '{1'b1, 32'h0003_5A25, 4'hA, 1'b1, 1'b1, 32'h0003_5A25, 4'hA},
        '{1'b1, 32'h0005_0801, 4'hB, 1'b1, 1'b1, 32'h0005_0801, 4'hB},
        '{1'b1, 32'h0006_0801, 4'hA, 1'b0, 1'b0, 32'h0, 4'h0},
        '{1'b1, 32'h0002_FF01, 4'hB, 1'b1, 1'b1, 32'h0002_FF01, 4'h1},
        '{1'b1, 32'h0002_FF05, 4'hB, 1'b1, 1'b1, 32'h0000_0704, 4'hB},
        '{1'b1, 32'h0002_FF01, 4'h1, 1'b0, 1'b0, 32'h0, 4'h0},
        '{1'b0, 32'h0001_FF01, 4'hB, 1'b1, 1'b0, 32'h0001_FF01, 4'h1},
        '{1'b0, 32'h0009_FF0D, 4'hB, 1'b1, 1'b0, 32'h0009_FF0D, 4'hB},
        '{1'b0, 32'h0003_FF0D, 4'hB, 1'b0, 1'b0, 32'h0, 4'h0},
        '{1'b0, 32'h0009_FF0D, 4'hA, 1'b0, 1'b0, 32'h0, 4'h0},
        '{1'b0, 32'h0002_0215, 4'hA, 1'b0, 1'b0, 32'h0, 4'h0},
        '{1'b0, 32'h0002_FF01, 4'h1, 1'b0, 1'b0, 32'h0, 4'h0}};

    cfg_fwd_core DUT (.clk(clk), .reset(reset), .primary_bus(8'h01),
        .secondary_bus(8'h02), .subordinate_bus(8'h05), .req_valid(req_valid),
        .req_primary(req_primary), .req_addr(req_addr), .req_cmd(req_cmd),
        .req_data(req_data), .req_multi(req_multi), .resp_valid_q(resp_valid_q),
        .resp_devsel_q(resp_devsel_q), .resp_trdy_q(resp_trdy_q),
        .resp_stop_q(resp_stop_q), .resp_data_q(resp_data_q), .fwd_ready(fwd_ready),
        .fwd_push_q(fwd_push_q), .fwd_to_secondary_q(fwd_to_secondary_q),
        .fwd_addr_q(fwd_addr_q), .fwd_cmd_q(fwd_cmd_q), .fwd_data_q(fwd_data_q),
        .fwd_single_q(fwd_single_q), .cpl_valid(cpl_valid),
        .cpl_master_abort(cpl_master_abort), .cpl_target_abort(cpl_target_abort),
        .cpl_data(cpl_data), .ma_report_q(ma_report_q));
    cfg_fwd_far_model far_end (.clk(clk), .reset(reset), .fwd_push_q(fwd_push_q),
        .fwd_addr_q(fwd_addr_q), .fwd_cmd_q(fwd_cmd_q), .cpl_delay(cpl_delay),
        .force_ta(force_ta), .fwd_ready(fwd_ready), .cpl_valid(cpl_valid),
        .cpl_master_abort(cpl_master_abort), .cpl_target_abort(cpl_target_abort),
        .cpl_data(cpl_data));

    // ============================================================
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one address phase; the registered answer stands for one cycle only, so it is
    // latched at the next falling edge, then an idle cycle keeps requests apart
    task automatic send(input case_t r, input logic multi, input logic [31:0] d);
        req_valid = 1'b1;
        req_primary = r.prim;
        req_addr = r.addr;
        req_cmd = r.cmd;
        req_multi = multi;
        req_data = d;
        @(negedge clk);
        seen_ans = {27'h0, fwd_push_q, resp_valid_q, resp_devsel_q, resp_trdy_q, resp_stop_q};
        req_valid = 1'b0;
        @(negedge clk);
    endtask
    // full delayed transaction: retry, push, completion, repeat
    task automatic run_row(input int i, input logic multi, input logic poke, input logic ta);
        case_t r;
        logic [31:0] d;
        logic ma;
        r = rows[i];
        d = {16'hDA7A, 16'(i)};
        ma = r.fcmd != 4'h1 && r.faddr[1:0] == 2'h0 && r.faddr[31:16] == 16'h0;
        force_ta = ta;
        send(r, 1'b0, d);
        check(seen_ans, r.push ? 32'h0000_001D : 32'h0);
        check(32'(seen_ans[4]), 32'(r.push));
        if (!r.push)
            return;
        check(fwd_addr_q, r.faddr);
        check(32'(fwd_cmd_q), 32'(r.fcmd));
        check(fwd_data_q, d);
        check(32'({fwd_to_secondary_q, fwd_single_q}), 32'({r.to_sec, 1'b1}));
        if (poke)
        begin
            send(r, 1'b0, d);
            check(seen_ans, 32'h0000_000D);
            send(rows[4], 1'b0, d);
            check(seen_ans, 32'h0000_000D);
        end
        for (int n = 0; n < 300 && cpl_valid !== 1'b1; n++)
            @(negedge clk);
        @(negedge clk);
        check(32'(ma_report_q), 32'(ma && !ta));
        send(r, multi, d);
        check(seen_ans, ta ? 32'h9 : ma ? 32'h8 : {28'h0, 3'h7, multi});
        if (r.cmd == 4'hA && !ma && !ta)
            check(resp_data_q, ~r.faddr);
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ============================================================
    // clock, watchdog and main sequence
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // the tests need well under 2000 cycles
    initial
    begin
        #100_000;
        miscompares++;
        report_and_stop();
    end
    initial
    begin
        reset = 1'b1;
        req_valid = 1'b0;
        req_primary = 1'b0;
        req_addr = 32'h0;
        req_cmd = 4'h0;
        req_data = 32'h0;
        req_multi = 1'b0;
        cpl_delay = 8'h00;
        force_ta = 1'b0;
        repeat (5) @(negedge clk);
        reset = 1'b0;
        for (int i = 0; i < 16; i++)
            run_row(i, 1'b0, 1'b0, 1'b0);
        // slow target: early repeat and an intruder both get retry
        cpl_delay = 8'h14;
        run_row(0, 1'b1, 1'b1, 1'b0);
        cpl_delay = 8'h02;
        run_row(7, 1'b1, 1'b0, 1'b0);
        run_row(10, 1'b1, 1'b0, 1'b0);
        run_row(4, 1'b0, 1'b0, 1'b1);
        // a request under reset is neither answered nor pushed
        reset = 1'b1;
        send(rows[0], 1'b0, 32'h0);
        check(seen_ans | 32'(ma_report_q) << 5, 32'h0);
        reset = 1'b0;
        run_row(1, 1'b0, 1'b0, 1'b0);
        report_and_stop();
    end
endmodule
